// >>> core/ibc_bit_ctrl.sv
`timescale 1ns/1ns
module ibc_bit_ctrl (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWrEn,
    input  wire logic       sfrRdEn,
    input  wire logic [7:0] sfrWdata,
    output logic      [7:0] sfrRdata,
    input  wire logic       mastershipRequest,
    input  wire logic       slaveEnable,
    input  wire logic       timerTimeout,
    input  wire logic       linkClk,
    input  wire logic       sclIn,
    output logic            sclOut,
    output logic            sclOe,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe
);
    // CPU-domain state.
    logic              dataReadyReg, arbLostReg, startSeenReg, stopSeenReg, masterReg;
    logic              txActiveReg, txBitReg, rxBitReg, slaveIdleReg, busBusyReg;
    logic              genStopReg, sdaLowReg, sdaNowReg, sclHoldReg;
    logic [9:0]        genCntReg;
    ibc_pkg::ibc_gen_t genStateReg;
    logic [3:0]        evPrevReg;
    logic [4:0]        evSync;
    // Link-domain state.
    logic              linkRst, sclPrevReg, sdaPrevReg, riseDlyReg, linkBitReg;
    logic [4:0]        linkSync;
    logic [3:0]        linkTogReg;
    // Combinational terms.
    logic              evRise, evFall, evStart, evStop, active, anyFlag, arbHit;
    logic              ctrlWr, ctrlRd, dataWr, dataRd, sclLvl, sdaLvl;
    logic              pushValid, fifoInReady, fifoOutValid, fifoOutData, popFire;

    // Decodes one register address against the bus address.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    assign ctrlWr  = sfrWrEn & hit(sfrAddr, ibc_pkg::CTRL_ADDR);
    assign ctrlRd  = sfrRdEn & hit(sfrAddr, ibc_pkg::CTRL_ADDR);
    assign dataWr  = sfrWrEn & hit(sfrAddr, ibc_pkg::DATA_ADDR);
    assign dataRd  = sfrRdEn & hit(sfrAddr, ibc_pkg::DATA_ADDR);
    assign anyFlag = dataReadyReg | arbLostReg | startSeenReg | stopSeenReg;
    assign active  = masterReg | (slaveEnable & ~slaveIdleReg);

    // Bus events arrive as toggles; a change marks one event each.
    assign evRise  = evSync[0] ^ evPrevReg[0];
    assign evFall  = evSync[1] ^ evPrevReg[1];
    assign evStart = evSync[2] ^ evPrevReg[2];
    assign evStop  = evSync[3] ^ evPrevReg[3];

    // Four ways to lose arbitration, all gated by transmit active.
    assign arbHit = txActiveReg & (
        (evRise & txBitReg & ~evSync[4]) |
        (evStart & txBitReg & genStateReg == ibc_pkg::IBC_GEN_NONE) |
        (masterReg & evFall & ~genStopReg &
         (genStateReg == ibc_pkg::IBC_GEN_WAIT ||
          genStateReg == ibc_pkg::IBC_GEN_DLY)) |
        (masterReg & evFall & genStopReg &
         genStateReg == ibc_pkg::IBC_GEN_HOLD));

    // Received bits queue here; the drain stalls while ready is pending.
    assign pushValid = evRise & active;
    assign popFire   = fifoOutValid & ~dataReadyReg;

    ibc_fifo #(.WIDTH(ibc_pkg::FIFO_WIDTH), .DEPTH(ibc_pkg::FIFO_DEPTH)) u_fifo (
        .clk(clk), .rst(sys_rst), .inValid(pushValid), .inReady(fifoInReady),
        .inData(evSync[4]), .outValid(fifoOutValid), .outReady(~dataReadyReg),
        .outData(fifoOutData));

    // Event toggles and the sampled SDA bit cross into the CPU domain.
    ibc_sync #(.W(5)) u_ev_sync (.clk(clk), .rst(sys_rst), .d({linkBitReg, linkTogReg}),
        .q(evSync));

    // Remembers the last toggle levels for event detection.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            evPrevReg <= 4'h0;
        end else begin
            evPrevReg <= evSync[3:0];
        end
    end

    // Register reads: status word for control, received bit for data.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sfrRdata <= ibc_pkg::CTRL_RESET;
        end else if (ctrlRd) begin
            sfrRdata[ibc_pkg::R_RXBIT]  <= rxBitReg;
            sfrRdata[ibc_pkg::R_ATTN]   <= anyFlag;
            sfrRdata[ibc_pkg::R_READY]  <= dataReadyReg;
            sfrRdata[ibc_pkg::R_ARB]    <= arbLostReg;
            sfrRdata[ibc_pkg::R_START]  <= startSeenReg;
            sfrRdata[ibc_pkg::R_STOP]   <= stopSeenReg;
            sfrRdata[ibc_pkg::R_MASTER] <= masterReg;
            sfrRdata[ibc_pkg::R_FILL]   <= 1'b1;
        end else if (dataRd) begin
            sfrRdata <= {rxBitReg, 7'h00};
        end
    end

    // Data-ready flag; a new bit wins over a clear in the same cycle.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dataReadyReg <= 1'b0;
        end else if (popFire) begin
            dataReadyReg <= 1'b1;
        end else if ((ctrlWr & sfrWdata[ibc_pkg::W_CLR_RDY]) | dataRd | dataWr) begin
            dataReadyReg <= 1'b0;
        end
    end

    // Received bit follows each bit leaving the queue.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rxBitReg <= 1'b1;
        end else if (popFire) begin
            rxBitReg <= fifoOutData;
        end
    end

    // Arbitration, start and stop flags; each set wins over its clear.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            arbLostReg   <= 1'b0;
            startSeenReg <= 1'b0;
            stopSeenReg  <= 1'b0;
        end else begin
            if (arbHit) begin
                arbLostReg <= 1'b1;
            end else if (ctrlWr & sfrWdata[ibc_pkg::W_CLR_ARB]) begin
                arbLostReg <= 1'b0;
            end
            if (evStart & active) begin
                startSeenReg <= 1'b1;
            end else if (ctrlWr & sfrWdata[ibc_pkg::W_CLR_START]) begin
                startSeenReg <= 1'b0;
            end
            if (evStop & active) begin
                stopSeenReg <= 1'b1;
            end else if (ctrlWr & sfrWdata[ibc_pkg::W_CLR_STOP]) begin
                stopSeenReg <= 1'b0;
            end
        end
    end

    // Transmit active: loss or timeout clear it before any set.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            txActiveReg <= 1'b0;
        end else if (arbHit | timerTimeout) begin
            txActiveReg <= 1'b0;
        end else if (dataWr | (ctrlWr & (sfrWdata[ibc_pkg::W_REP_START] |
                                         sfrWdata[ibc_pkg::W_SEND_STOP]))) begin
            txActiveReg <= 1'b1;
        end else if ((ctrlWr & sfrWdata[ibc_pkg::W_CLR_TX]) | dataRd) begin
            txActiveReg <= 1'b0;
        end
    end

    // Bit to send: data writes, repeated start sends one, stop zero.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            txBitReg <= 1'b1;
        end else if (dataWr) begin
            txBitReg <= sfrWdata[7];
        end else if (ctrlWr & sfrWdata[ibc_pkg::W_REP_START]) begin
            txBitReg <= 1'b1;
        end else if (ctrlWr & sfrWdata[ibc_pkg::W_SEND_STOP]) begin
            txBitReg <= 1'b0;
        end
    end

    // Slave idle until the next start; the start itself wins.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slaveIdleReg <= 1'b1;
        end else if (evStart) begin
            slaveIdleReg <= 1'b0;
        end else if ((ctrlWr & sfrWdata[ibc_pkg::W_IDLE]) | timerTimeout) begin
            slaveIdleReg <= 1'b1;
        end
    end

    // Bus busy from a start until a stop or a bus timeout.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busBusyReg <= 1'b0;
        end else if (evStop | timerTimeout) begin
            busBusyReg <= 1'b0;
        end else if (evStart) begin
            busBusyReg <= 1'b1;
        end
    end

    // Mastership taken on request while free, given up on loss or stop.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            masterReg <= 1'b0;
        end else if (arbHit | timerTimeout |
                     (ctrlWr & sfrWdata[ibc_pkg::W_SEND_STOP] & ~mastershipRequest)) begin
            masterReg <= 1'b0;
        end else if (mastershipRequest & ~busBusyReg) begin
            masterReg <= 1'b1;
        end
    end

    // Start and stop generation: wait for SCL high, wait, then move SDA.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            genStateReg <= ibc_pkg::IBC_GEN_NONE;
            genStopReg  <= 1'b0;
            genCntReg   <= 10'h000;
        end else if (arbHit | timerTimeout) begin
            genStateReg <= ibc_pkg::IBC_GEN_NONE;
        end else begin
            unique case (genStateReg)
                ibc_pkg::IBC_GEN_NONE: begin
                    if (ctrlWr & (sfrWdata[ibc_pkg::W_REP_START] |
                                  sfrWdata[ibc_pkg::W_SEND_STOP])) begin
                        genStateReg <= ibc_pkg::IBC_GEN_WAIT;
                        genStopReg  <= ~sfrWdata[ibc_pkg::W_REP_START];
                    end
                end
                ibc_pkg::IBC_GEN_WAIT: begin
                    genCntReg <= 10'h000;
                    if (evRise) begin
                        genStateReg <= ibc_pkg::IBC_GEN_DLY;
                    end
                end
                ibc_pkg::IBC_GEN_DLY: begin
                    genCntReg <= genCntReg + 10'h001;
                    if (genCntReg == ibc_pkg::MIN_LAST) begin
                        genStateReg <= ibc_pkg::IBC_GEN_HOLD;
                    end
                end
                ibc_pkg::IBC_GEN_HOLD: begin
                    if (evFall | evStop) begin
                        genStateReg <= ibc_pkg::IBC_GEN_NONE;
                    end
                end
            endcase
        end
    end

    // Pin requests sent to the link; SCL held while any flag is pending.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sdaLowReg  <= 1'b0;
            sdaNowReg  <= 1'b0;
            sclHoldReg <= 1'b0;
        end else begin
            sdaNowReg  <= genStateReg == ibc_pkg::IBC_GEN_HOLD;
            sdaLowReg  <= (genStateReg == ibc_pkg::IBC_GEN_HOLD) ? ~genStopReg
                          : (txActiveReg & ~txBitReg);
            sclHoldReg <= anyFlag | fifoOutValid | ~fifoInReady;
        end
    end

    // Link-domain reset and synchronised pins and CPU requests.
    ibc_sync #(.W(1)) u_rst_sync (.clk(linkClk), .rst(1'b0), .d(sys_rst), .q(linkRst));
    // Pins enter inverted so a cleared synchroniser reads as idle-high lines, no false edge.
    ibc_sync #(.W(5)) u_link_sync (.clk(linkClk), .rst(linkRst),
        .d({sclHoldReg, sdaNowReg, sdaLowReg, ~sdaIn, ~sclIn}), .q(linkSync));
    assign sclLvl = ~linkSync[0];
    assign sdaLvl = ~linkSync[1];

    // Condition detection on the link clock; events leave as toggles.
    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            sclPrevReg <= 1'b1;
            sdaPrevReg <= 1'b1;
            riseDlyReg <= 1'b0;
            linkBitReg <= 1'b1;
            linkTogReg <= 4'h0;
        end else begin
            sclPrevReg <= sclLvl;
            sdaPrevReg <= sdaLvl;
            riseDlyReg <= sclLvl & ~sclPrevReg;
            if (sclLvl & ~sclPrevReg) begin
                linkBitReg <= sdaLvl;
            end
            linkTogReg[0] <= linkTogReg[0] ^ riseDlyReg;
            linkTogReg[1] <= linkTogReg[1] ^ (~sclLvl & sclPrevReg);
            linkTogReg[2] <= linkTogReg[2] ^
                             (sclLvl & sclPrevReg & sdaPrevReg & ~sdaLvl);
            linkTogReg[3] <= linkTogReg[3] ^
                             (sclLvl & sclPrevReg & ~sdaPrevReg & sdaLvl);
        end
    end

    // Pin drivers; data changes only while SCL is low, or at any time while start/stop generation is in its hold state.
    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            sclOe  <= 1'b0;
            sdaOe  <= 1'b0;
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
        end else begin
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
            sclOe  <= linkSync[4] & (sclOe | ~sclLvl);
            if (linkSync[3] | ~sclLvl) begin
                sdaOe <= linkSync[2];
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_attn;
        ctrlRd |=> sfrRdata[ibc_pkg::R_ATTN] == $past(anyFlag);
    endproperty
    a_attn: assert property (p_attn) else $error("attention bit wrong");
    property p_rdquiet;
        ctrlRd & ~sfrWrEn & ~arbHit & ~evStart & ~evStop & ~popFire
            |=> $stable({arbLostReg, startSeenReg, stopSeenReg, dataReadyReg});
    endproperty
    a_rdquiet: assert property (p_rdquiet) else $error("read changed flags");
    property p_hold;
        (arbLostReg | startSeenReg | stopSeenReg) ##1 1'b1 |-> sclHoldReg;
    endproperty
    a_hold: assert property (p_hold) else $error("SCL released early");
    property p_arbtx;
        $rose(arbLostReg) |-> ~txActiveReg && $past(txActiveReg);
    endproperty
    a_arbtx: assert property (p_arbtx) else $error("loss without transmit");
    property p_idlestart;
        evStart & ~active & ~startSeenReg |=> ~startSeenReg;
    endproperty
    a_idlestart: assert property (p_idlestart) else $error("start at idle slave");
    property p_master;
        mastershipRequest & ~busBusyReg & ~timerTimeout & ~arbHit & ~ctrlWr
            |=> masterReg;
    endproperty
    a_master: assert property (p_master) else $error("master not taken");
    property p_lossmaster;
        $rose(arbLostReg) |-> ~masterReg;
    endproperty
    a_lossmaster: assert property (p_lossmaster) else $error("master kept");
    property p_cleartx;
        ctrlWr & sfrWdata[ibc_pkg::W_CLR_TX] & ~sfrWdata[ibc_pkg::W_REP_START] &
            ~sfrWdata[ibc_pkg::W_SEND_STOP] |=> ~txActiveReg;
    endproperty
    a_cleartx: assert property (p_cleartx) else $error("transmit not cleared");
    property p_ready;
        pushValid & fifoInReady & ~dataReadyReg & ~fifoOutValid ##1 ~dataRd & ~dataWr
            |=> dataReadyReg;
    endproperty
    a_ready: assert property (p_ready) else $error("ready not set");
    property p_dread;
        dataRd |=> sfrRdata == {$past(rxBitReg), 7'h00};
    endproperty
    a_dread: assert property (p_dread) else $error("data read wrong");
    c_arb:    cover property ($rose(arbLostReg));
    c_start:  cover property ($rose(startSeenReg));
    c_master: cover property ($rose(masterReg));
    c_ready:  cover property ($rose(dataReadyReg));
endmodule

// >>> core/ibc_pkg.sv
// Notes on behaviour
// - Control reads return flags; writes are strobes.
// - Control reads have no side effects.
// - Pending arb/start/stop flag keeps SCL held low.
// - Arbitration loss only while transmitting; clears it.
// - Sent one, SDA low at rise: arbitration lost.
// - Foreign repeated start over our one: lost, start.
// - Our repeated start beaten by early SCL fall.
// - Our stop beaten by SCL fall in the hold state.
// - Start flag only at master or awake slave.
// - Stop flag only at master or awake slave.
// - Master set on request while bus free.
// - Master cleared by loss or stop without request.
// - Clear-transmit strobe or data read ends transmit.
// - Attention is OR of the four flags.
// - Ready on each SCL rise while active; SCL held low.
// - SDA captured at rise; data register shows it.
package ibc_pkg;
    localparam logic [7:0] CTRL_ADDR  = 8'hD8;
    localparam logic [7:0] DATA_ADDR  = 8'hD9;
    localparam logic [7:0] CTRL_RESET = 8'h81;
    // Read-side field positions of the control register.
    localparam int R_RXBIT  = 7;
    localparam int R_ATTN   = 6;
    localparam int R_READY  = 5;
    localparam int R_ARB    = 4;
    localparam int R_START  = 3;
    localparam int R_STOP   = 2;
    localparam int R_MASTER = 1;
    localparam int R_FILL   = 0;
    // Write-side strobe positions of the control register.
    localparam int W_CLR_TX    = 7;
    localparam int W_IDLE      = 6;
    localparam int W_CLR_RDY   = 5;
    localparam int W_CLR_ARB   = 4;
    localparam int W_CLR_START = 3;
    localparam int W_CLR_STOP  = 2;
    localparam int W_REP_START = 1;
    localparam int W_SEND_STOP = 0;
    // Timing of generated start and stop conditions.
    localparam int CLK_PERIOD_NS = 8;
    localparam int MIN_TIME_NS   = 4700;
    localparam int MIN_TIME_CYC  = (MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] MIN_LAST = 10'(MIN_TIME_CYC - 1);
    localparam int FIFO_WIDTH = 1;
    localparam int FIFO_DEPTH = 16;
    typedef enum logic [1:0] {
        IBC_GEN_NONE = 2'b00,
        IBC_GEN_WAIT = 2'b01,
        IBC_GEN_DLY  = 2'b10,
        IBC_GEN_HOLD = 2'b11
    } ibc_gen_t;
endpackage

// >>> core/ibc_sync.sv
`timescale 1ns/1ns
module ibc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] stage1Reg;

    // Two flip-flops per bit; the first is read only by the second.
    always_ff @(posedge clk) begin
        if (rst) begin
            stage1Reg <= '0;
            q         <= '0;
        end else begin
            stage1Reg <= d;
            q         <= stage1Reg;
        end
    end
endmodule

// >>> core/ibc_fifo.sv
`timescale 1ns/1ns
module ibc_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] memReg [DEPTH];
    logic [AW-1:0]    wrPtrReg;
    logic [AW-1:0]    rdPtrReg;
    logic [AW:0]      countReg;
    logic             push;
    logic             pop;

    // Honest full and empty come straight from the fill count.
    assign inReady  = (countReg != (AW+1)'(DEPTH));
    assign outValid = (countReg != '0);
    assign outData  = memReg[rdPtrReg];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    // Storage written at the write index.
    always_ff @(posedge clk) begin
        if (push) begin
            memReg[wrPtrReg] <= inData;
        end
    end

    // Pointers and fill count.
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtrReg <= '0;
            rdPtrReg <= '0;
            countReg <= '0;
        end else begin
            if (push) begin
                wrPtrReg <= (wrPtrReg == AW'(DEPTH - 1)) ? '0 : wrPtrReg + 1'b1;
            end
            if (pop) begin
                rdPtrReg <= (rdPtrReg == AW'(DEPTH - 1)) ? '0 : rdPtrReg + 1'b1;
            end
            countReg <= countReg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// >>> sim/ibc_bus_model.sv
`timescale 1ns/1ns
module ibc_bus_model (
    input  wire logic linkClk,
    input  wire logic sclIn,
    output logic      sclLow,
    output logic      sdaLow
);
    int stalls = 0;
    // Both lines start released and float high on their pull-ups.
    initial begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
    end
    // Releases SCL and waits, bounded, while the device stretches it low.
    task automatic rise();
        int i;
        @(posedge linkClk);
        sclLow <= 1'b0;
        for (i = 0; i < 3000 && sclIn !== 1'b1; i++) @(posedge linkClk);
        if (i == 3000) stalls++;
        repeat (20) @(posedge linkClk);
    endtask
    // Sets one data bit in the low phase, clocks it and pulls SCL low again.
    task automatic bit_out(input logic b);
        @(posedge linkClk);
        sdaLow <= ~b;
        repeat (8) @(posedge linkClk);
        rise();
        sclLow <= 1'b1;
        repeat (8) @(posedge linkClk);
    endtask
    // Start: SDA falls while SCL is high, then SCL is pulled low.
    task automatic start_cond();
        @(posedge linkClk);
        sdaLow <= 1'b1;
        repeat (20) @(posedge linkClk);
        sclLow <= 1'b1;
        repeat (8) @(posedge linkClk);
    endtask
    // Stop: SDA is low across the rise, then released while SCL is high.
    task automatic stop_cond();
        @(posedge linkClk);
        sdaLow <= 1'b1;
        repeat (8) @(posedge linkClk);
        rise();
        sdaLow <= 1'b0;
        repeat (20) @(posedge linkClk);
    endtask
endmodule

// >>> sim/testbench.sv
`timescale 1ns/1ns
module testbench;
    localparam logic [7:0] CA = ibc_pkg::CTRL_ADDR;
    localparam logic [7:0] DA = ibc_pkg::DATA_ADDR;
    logic        clk = 1'b0;
    logic        linkClk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  sfrAddr = 8'h00;
    logic        sfrWrEn = 1'b0;
    logic        sfrRdEn = 1'b0;
    logic [7:0]  sfrWdata = 8'h00;
    logic [7:0]  sfrRdata;
    logic        mReq = 1'b0;
    logic        tmo = 1'b0;
    logic        sclOut, sclOe, sdaOut, sdaOe, sclLow, sdaLow, sclIn, sdaIn;
    logic [7:0]  rd;
    logic [31:0] seed = 32'h107F0;
    logic        sent[$];
    int          mismatches = 0;
    int          samples_checked = 0;
    // CPU clock and an unrelated 15 ns link clock.
    always #4 clk = ~clk;
    initial begin
        #3;
        forever begin
            #7 linkClk = 1'b1;
            #8 linkClk = 1'b0;
        end
    end
    // Open-drain wires: any party pulling low wins over the pull-up.
    assign sclIn = ~(sclLow | sclOe);
    assign sdaIn = ~(sdaLow | sdaOe);
    ibc_bit_ctrl dut_u (.clk(clk), .sys_rst(sys_rst), .sfrAddr(sfrAddr),
        .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
        .mastershipRequest(mReq), .slaveEnable(1'b1), .timerTimeout(tmo),
        .linkClk(linkClk), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
        .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe));
    ibc_bus_model busModel (.linkClk(linkClk), .sclIn(sclIn), .sclLow(sclLow),
        .sdaLow(sdaLow));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfrAddr <= a;
        sfrWdata <= d;
        sfrWrEn <= 1'b1;
        @(posedge clk);
        sfrWrEn <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdr(input logic [7:0] a);
        sfrAddr <= a;
        sfrRdEn <= 1'b1;
        @(posedge clk);
        sfrRdEn <= 1'b0;
        @(posedge clk);
        rd = sfrRdata;
    endtask
    // Polls the control register, bounded, until the given flag reads set.
    task automatic poll(input int b);
        for (int i = 0; i < 400; i++) begin
            rdr(CA);
            if (rd[b] === 1'b1) break;
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Expected control reads are {rx, attn, ready, arb, start, stop, master, 1}.
    initial begin
        logic b;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rdr(CA);
        chk(ibc_pkg::CTRL_RESET, rd);
        wr(CA, 8'hFC);
        rdr(CA);
        chk(8'h81, rd);
        rdr(8'h00);
        chk(8'h81, rd);
        $display("test registers done");
        busModel.start_cond();
        rdr(CA);
        chk(8'h81, rd);
        for (int n = 0; n < 8; n++) begin
            seed = xs(seed);
            b = seed[0];
            sent.push_back(b);
            busModel.bit_out(b);
            poll(ibc_pkg::R_READY);
            chk({b, 7'h61}, rd);
            rdr(CA);
            chk({b, 7'h61}, rd);
            rdr(DA);
            chk({sent.pop_front(), 7'h00}, rd);
        end
        $display("test receive done");
        wr(DA, 8'h80);
        busModel.bit_out(1'b0);
        poll(ibc_pkg::R_ARB);
        chk(8'h71, rd);
        wr(CA, 8'h20);
        repeat (40) @(posedge clk);
        chk(8'h01, {7'h00, sclOe});
        wr(CA, 8'h10);
        repeat (40) @(posedge clk);
        chk(8'h00, {7'h00, sclOe});
        wr(DA, 8'h00);
        repeat (40) @(posedge clk);
        chk(8'h01, {4'h0, sclOut, sdaOut, sclOe, sdaOe});
        wr(CA, 8'h80);
        repeat (40) @(posedge clk);
        chk(8'h00, {4'h0, sclOut, sdaOut, sclOe, sdaOe});
        busModel.stop_cond();
        poll(ibc_pkg::R_STOP);
        chk(8'h65, rd);
        wr(CA, 8'h24);
        $display("test arbitration done");
        mReq <= 1'b1;
        poll(ibc_pkg::R_MASTER);
        chk(8'h03, rd);
        mReq <= 1'b0;
        wr(CA, 8'h21);
        rdr(CA);
        chk(8'h01, rd);
        tmo <= 1'b1;
        @(posedge clk);
        tmo <= 1'b0;
        rdr(CA);
        chk(8'h01, rd);
        chk(8'h00, busModel.stalls[7:0]);
        $display("test master done");
        wrap_up();
    end
    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
endmodule
